// *** rtl/asec_pkg.sv ***
// Purpose: Constants and types for the serial extension control block
// Assumes: Classic Wishbone slave, 32-bit data, byte addresses
// Notes: Channel 0 carries the receiver, transmitter and baud generator

package asec_pkg;

	// ----------------------------------------------------------------
	// Register offsets
	// ----------------------------------------------------------------
	localparam int ADDR_W = 5;
	localparam logic [4:0] OFF_EXT0 = 5'h00;
	localparam logic [4:0] OFF_EXT1 = 5'h04;
	localparam logic [4:0] OFF_CFG = 5'h08;
	localparam logic [4:0] OFF_TCONST = 5'h0c;
	localparam logic [4:0] OFF_CTRLA = 5'h10;
	localparam logic [4:0] OFF_DATA = 5'h14;
	localparam logic [4:0] OFF_STAT = 5'h18;

	// ----------------------------------------------------------------
	// Extension control fields and reset values
	// ----------------------------------------------------------------
	localparam int EXT_CD_DIS = 6;
	localparam int EXT_CTS_DIS = 5;
	localparam int EXT_X1 = 4;
	localparam int EXT_BRG_MODE = 3;
	localparam int EXT_BRK_EN = 2;
	localparam int EXT_BRK_DET = 1;
	localparam int EXT_SEND_BRK = 0;
	localparam logic [7:0] EXT_RESET = 8'h00;
	localparam logic [7:0] EXT0_WMASK = 8'h7d;
	localparam logic [7:0] EXT1_WMASK = 8'h1d;
	localparam logic [7:0] CFG_RESET = 8'h00;
	localparam logic [15:0] TCONST_RESET = 16'h0000;

	// ----------------------------------------------------------------
	// Config, control and status fields
	// ----------------------------------------------------------------
	localparam int CFG_PRESCALE = 3;
	localparam int CFG_OVS = 4;
	localparam int CFG_CTS_LVL = 5;
	localparam int CTRLA_EFR = 0;
	localparam int CTRLA_IO_STOP_MODE = 1;
	localparam int STAT_RX_AVAIL = 0;
	localparam int STAT_FE = 1;
	localparam int STAT_TX_EMPTY = 2;
	localparam int STAT_CD_LVL = 3;
	localparam int STAT_CTS_LVL = 4;
	localparam int STAT_CD_RISE = 5;

	// ----------------------------------------------------------------
	// Divider figures
	// ----------------------------------------------------------------
	localparam logic [17:0] PRESCALE_LO = 18'h0000a;
	localparam logic [17:0] PRESCALE_HI = 18'h0001e;
	localparam logic [17:0] TC_OFFSET = 18'h00002;
	localparam logic [2:0] RATE_EXT = 3'h7;
	localparam logic [6:0] OVS_UNITY = 7'h01;
	localparam logic [6:0] OVS_LO = 7'h10;
	localparam logic [6:0] OVS_HI = 7'h40;
	localparam logic [8:0] BREAK_ENTRY = 9'h100;

	typedef enum logic [1:0] {SER_IDLE, SER_START, SER_DATA, SER_STOP} asec_ser_t;

endpackage

// *** rtl/asec_baud_if.sv ***
// Purpose: Link between the control block and its baud generator
// Assumes: All signals on ref_clk
// Notes: extClk is already synchronised by the user side
`timescale 1ns/10ps
interface asec_baud_if;
	logic [2:0] rateSel;
	logic prescale;
	logic genMode;
	logic [15:0] timeConst;
	logic extClk;
	logic tick;
	logic clkLevel;
	logic clkDrive;

	modport gen (input rateSel, prescale, genMode, timeConst, extClk,
		output tick, clkLevel, clkDrive);
	modport user (output rateSel, prescale, genMode, timeConst, extClk,
		input tick, clkLevel, clkDrive);
endinterface

// *** rtl/asec_baud_gen.sv ***
// Purpose: Baud generator producing a one-cycle tick enable
// Assumes: Synchronous active-high reset
// Notes: Rate 111 takes rising edges of the synchronised clock pin
`timescale 1ns/10ps
module asec_baud_gen (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// Generator link
	asec_baud_if.gen bus
);
	logic [17:0] cnt, next_cnt;
	logic [17:0] period;
	logic tick, next_tick;
	logic level, next_level;
	logic drive, next_drive;
	logic extPrev, next_extPrev;

	function automatic logic [17:0] calcPeriod(input logic mode, input logic pre,
			input logic [2:0] rate, input logic [15:0] tc);
		if (mode) begin
			calcPeriod = (18'(tc) + asec_pkg::TC_OFFSET) << 1;
		end else begin
			calcPeriod = (pre ? asec_pkg::PRESCALE_HI : asec_pkg::PRESCALE_LO) << rate;
		end
	endfunction

	always_comb begin
		period = calcPeriod(bus.genMode, bus.prescale, bus.rateSel, bus.timeConst);
		next_extPrev = bus.extClk;
		next_tick = 1'b0;
		next_cnt = cnt + 18'h00001;
		next_drive = bus.rateSel != asec_pkg::RATE_EXT;
		next_level = cnt < (period >> 1);
		if (bus.rateSel == asec_pkg::RATE_EXT) begin
			next_cnt = 18'h00000;
			next_level = 1'b0;
			next_tick = bus.extClk && !extPrev;
		end else if (cnt >= period - 18'h00001) begin
			next_cnt = 18'h00000;
			next_tick = 1'b1;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			cnt <= 18'h00000;
			tick <= 1'b0;
			level <= 1'b0;
			drive <= 1'b0;
			extPrev <= 1'b0;
		end else begin
			cnt <= next_cnt;
			tick <= next_tick;
			level <= next_level;
			drive <= next_drive;
			extPrev <= next_extPrev;
		end
	end

	assign bus.tick = tick;
	assign bus.clkLevel = level;
	assign bus.clkDrive = drive;
endmodule // asec_baud_gen

// *** rtl/asec_ext_ctrl.sv ***
// Purpose: Serial extension control with channel 0 receiver and transmitter
// Assumes: Classic Wishbone, one wait state per access
// Notes: Channel 1 register is stored only; channel 0 drives the logic
//
// Implementation choices: register access over Wishbone and the placing of the registers.
`timescale 1ns/10ps
module asec_ext_ctrl #(
	parameter int FIFO_DEPTH = 4
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// Wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [4:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// Serial pins
	input wire logic rx_serial_pin,
	output logic tx_serial_pin,
	input wire logic carrier_detect_in,
	input wire logic clear_to_send_in,
	input wire logic async_clock_pin_in,
	output logic async_clock_pin_out,
	output logic async_clock_pin_oe,
	// Status
	output logic tx_empty_flag,
	output logic carrier_rise_event
);
	localparam int PW = $clog2(FIFO_DEPTH);

	// ----------------------------------------------------------------
	// Pin synchronisers
	// ----------------------------------------------------------------
	logic [1:0] rxS, cdS, ctsS, ckS;
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			rxS <= 2'h3;
			cdS <= 2'h3;
			ctsS <= 2'h3;
			ckS <= 2'h0;
		end else begin
			rxS <= {rxS[0], rx_serial_pin};
			cdS <= {cdS[0], carrier_detect_in};
			ctsS <= {ctsS[0], clear_to_send_in};
			ckS <= {ckS[0], async_clock_pin_in};
		end
	end

	// ----------------------------------------------------------------
	// Registers and derived controls
	// ----------------------------------------------------------------
	logic [7:0] ext0, ext1, cfg, next_ext0, next_ext1, next_cfg;
	logic [15:0] tconst, next_tconst;
	logic io_stop_mode, next_io_stop_mode;
	logic [31:0] next_dat;
	logic next_ack, cdPrev, cdSticky, next_cdSticky;
	logic req, wr, rd, cdLvl, ctsLvl, rxHold, ctsBlock, brkEn;
	logic pop, efrZero, txLoad;
	logic holdValid;
	logic [PW:0] count;
	logic [8:0] oldest;
	logic [6:0] div, half;

	asec_baud_if baud ();

	function automatic logic [6:0] ovsDiv(input logic x1, input logic dr);
		if (x1) begin
			ovsDiv = asec_pkg::OVS_UNITY;
		end else begin
			ovsDiv = dr ? asec_pkg::OVS_HI : asec_pkg::OVS_LO;
		end
	endfunction

	function automatic logic selWrite(input logic [4:0] off);
		selWrite = wr && wb_adr_i == off && wb_sel_i[0];
	endfunction

	assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
	assign wr = req && wb_we_i;
	assign rd = req && !wb_we_i;
	assign cdLvl = cdS[1];
	assign ctsLvl = ctsS[1];
	assign rxHold = !ext0[asec_pkg::EXT_CD_DIS] && cdLvl;
	assign ctsBlock = !ext0[asec_pkg::EXT_CTS_DIS] && ctsLvl;
	assign brkEn = ext0[asec_pkg::EXT_BRK_EN];
	assign div = ovsDiv(ext0[asec_pkg::EXT_X1], cfg[asec_pkg::CFG_OVS]);
	assign half = div >> 1;
	assign pop = rd && wb_adr_i == asec_pkg::OFF_DATA && count != '0;
	assign efrZero = selWrite(asec_pkg::OFF_CTRLA) && !wb_dat_i[asec_pkg::CTRLA_EFR];
	assign txLoad = selWrite(asec_pkg::OFF_DATA) && !holdValid;

	assign baud.rateSel = cfg[2:0];
	assign baud.prescale = cfg[asec_pkg::CFG_PRESCALE];
	assign baud.genMode = ext0[asec_pkg::EXT_BRG_MODE];
	assign baud.timeConst = tconst;
	assign baud.extClk = ckS[1];

	asec_baud_gen u_baud (
		.ref_clk(ref_clk),
		.rst(rst),
		.bus(baud.gen)
	);

	always_comb begin
		next_ext0 = ext0;
		next_ext1 = ext1;
		next_cfg = cfg;
		next_tconst = tconst;
		next_io_stop_mode = io_stop_mode;
		next_ack = req;
		next_dat = 32'h00000000;
		if (selWrite(asec_pkg::OFF_EXT0)) begin
			next_ext0 = (wb_dat_i[7:0] & asec_pkg::EXT0_WMASK) | (ext0 & ~asec_pkg::EXT0_WMASK);
		end
		if (selWrite(asec_pkg::OFF_EXT1)) begin
			next_ext1 = wb_dat_i[7:0] & asec_pkg::EXT1_WMASK;
		end
		if (selWrite(asec_pkg::OFF_CFG)) begin
			next_cfg = {3'h0, wb_dat_i[4:0]};
		end
		if (selWrite(asec_pkg::OFF_TCONST)) begin
			next_tconst[7:0] = wb_dat_i[7:0];
		end
		if (wr && wb_adr_i == asec_pkg::OFF_TCONST && wb_sel_i[1]) begin
			next_tconst[15:8] = wb_dat_i[15:8];
		end
		if (selWrite(asec_pkg::OFF_CTRLA)) begin
			next_io_stop_mode = wb_dat_i[asec_pkg::CTRLA_IO_STOP_MODE];
		end
		if (count != '0 && oldest == asec_pkg::BREAK_ENTRY && brkEn) begin
			next_ext0[asec_pkg::EXT_BRK_DET] = 1'b1;
		// write 0, io stop, carrier loss
		end else if (efrZero || io_stop_mode || rxHold) begin
			next_ext0[asec_pkg::EXT_BRK_DET] = 1'b0;
		end
		next_cdSticky = cdSticky;
		if (rd && wb_adr_i == asec_pkg::OFF_STAT) begin
			next_cdSticky = 1'b0;
		end
		if (cdLvl && !cdPrev) begin
			next_cdSticky = 1'b1;
		end
		if (rd) begin
			case (wb_adr_i)
				asec_pkg::OFF_EXT0: next_dat[7:0] = ext0;
				asec_pkg::OFF_EXT1: next_dat[7:0] = ext1;
				asec_pkg::OFF_CFG: next_dat[7:0] = cfg | {2'h0, ctsLvl, 5'h00};
				asec_pkg::OFF_TCONST: next_dat[15:0] = tconst;
				asec_pkg::OFF_CTRLA: next_dat[1:0] = {io_stop_mode, 1'b1};
				asec_pkg::OFF_DATA: next_dat[7:0] = oldest[7:0];
				asec_pkg::OFF_STAT: next_dat[5:0] = {cdSticky, ctsLvl, cdLvl,
					tx_empty_flag, oldest[8] && count != '0, count != '0};
				default: next_dat = 32'h00000000;
			endcase
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			ext0 <= asec_pkg::EXT_RESET;
			ext1 <= asec_pkg::EXT_RESET;
			cfg <= asec_pkg::CFG_RESET;
			tconst <= asec_pkg::TCONST_RESET;
			io_stop_mode <= 1'b0;
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h00000000;
			cdPrev <= 1'b1;
			cdSticky <= 1'b0;
		end else begin
			ext0 <= next_ext0;
			ext1 <= next_ext1;
			cfg <= next_cfg;
			tconst <= next_tconst;
			io_stop_mode <= next_io_stop_mode;
			wb_ack_o <= next_ack;
			wb_dat_o <= next_dat;
			cdPrev <= cdLvl;
			cdSticky <= next_cdSticky;
		end
	end

	// ----------------------------------------------------------------
	// Receiver and FIFO
	// ----------------------------------------------------------------
	asec_pkg::asec_ser_t rxSt, next_rxSt;
	logic [6:0] rxSub, next_rxSub;
	logic [2:0] rxIdx, next_rxIdx;
	logic [7:0] rxSh, next_rxSh;
	logic [8:0] mem [FIFO_DEPTH];
	logic [PW-1:0] wrPtr, rdPtr, next_wrPtr, next_rdPtr;
	logic [PW:0] next_count;
	logic push;
	logic [8:0] pushVal;

	assign oldest = mem[rdPtr];

	always_comb begin
		next_rxSt = rxSt;
		next_rxSub = rxSub;
		next_rxIdx = rxIdx;
		next_rxSh = rxSh;
		push = 1'b0;
		pushVal = {1'b0, rxSh};
		if (baud.tick) begin
			case (rxSt)
				asec_pkg::SER_IDLE: begin
					if (!rxS[1]) begin
						next_rxSt = half == 7'h00 ? asec_pkg::SER_DATA : asec_pkg::SER_START;
						next_rxSub = 7'h01;
						next_rxIdx = 3'h0;
					end
				end
				asec_pkg::SER_START: begin
					next_rxSub = rxSub + 7'h01;
					if (rxSub == half) begin
						next_rxSt = rxS[1] ? asec_pkg::SER_IDLE : asec_pkg::SER_DATA;
						next_rxSub = 7'h01;
					end
				end
				asec_pkg::SER_DATA: begin
					next_rxSub = rxSub + 7'h01;
					if (rxSub == div) begin
						next_rxSh = {rxS[1], rxSh[7:1]};
						next_rxSub = 7'h01;
						next_rxIdx = rxIdx + 3'h1;
						if (rxIdx == 3'h7) begin
							next_rxSt = asec_pkg::SER_STOP;
						end
					end
				end
				asec_pkg::SER_STOP: begin
					next_rxSub = rxSub + 7'h01;
					if (rxSub == div) begin
						push = 1'b1;
						pushVal = {!rxS[1], rxSh};
						next_rxSt = asec_pkg::SER_IDLE;
					end
				end
				default: next_rxSt = asec_pkg::SER_IDLE;
			endcase
		end
		// Full FIFO drops the character; overrun status is not kept here
		push = push && count != (PW + 1)'(FIFO_DEPTH);
		next_wrPtr = push ? wrPtr + PW'(1) : wrPtr;
		next_rdPtr = pop ? rdPtr + PW'(1) : rdPtr;
		next_count = count + {{PW{1'b0}}, push} - {{PW{1'b0}}, pop};
		if (rxHold || io_stop_mode) begin
			next_rxSt = asec_pkg::SER_IDLE;
			next_wrPtr = '0;
			next_rdPtr = '0;
			next_count = '0;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			rxSt <= asec_pkg::SER_IDLE;
			rxSub <= 7'h00;
			rxIdx <= 3'h0;
			rxSh <= 8'h00;
			wrPtr <= '0;
			rdPtr <= '0;
			count <= '0;
		end else begin
			rxSt <= next_rxSt;
			rxSub <= next_rxSub;
			rxIdx <= next_rxIdx;
			rxSh <= next_rxSh;
			wrPtr <= next_wrPtr;
			rdPtr <= next_rdPtr;
			count <= next_count;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (push && !(rxHold || io_stop_mode)) begin
			mem[wrPtr] <= pushVal;
		end
	end

	// ----------------------------------------------------------------
	// Transmitter
	// ----------------------------------------------------------------
	asec_pkg::asec_ser_t txSt, next_txSt;
	logic [6:0] txSub, next_txSub;
	logic [2:0] txIdx, next_txIdx;
	logic [7:0] txSh, next_txSh, txHold, next_txHold;
	logic next_holdValid, txLine, next_txLine;

	always_comb begin
		next_txSt = txSt;
		next_txSub = txSub;
		next_txIdx = txIdx;
		next_txSh = txSh;
		next_txLine = txLine;
		next_txHold = txLoad ? wb_dat_i[7:0] : txHold;
		next_holdValid = holdValid || txLoad;
		if (txSt == asec_pkg::SER_IDLE) begin
			if (holdValid && !ctsBlock) begin
				next_txSt = asec_pkg::SER_START;
				next_txSh = txHold;
				next_holdValid = 1'b0;
				next_txLine = 1'b0;
				next_txSub = 7'h00;
			end
		end else if (baud.tick) begin
			next_txSub = txSub + 7'h01;
			if (txSub == div - 7'h01) begin
				next_txSub = 7'h00;
				case (txSt)
					asec_pkg::SER_START: begin
						next_txSt = asec_pkg::SER_DATA;
						next_txLine = txSh[0];
						next_txIdx = 3'h0;
					end
					asec_pkg::SER_DATA: begin
						next_txIdx = txIdx + 3'h1;
						next_txSh = {1'b0, txSh[7:1]};
						next_txLine = txSh[1];
						if (txIdx == 3'h7) begin
							next_txSt = asec_pkg::SER_STOP;
							next_txLine = 1'b1;
						end
					end
					asec_pkg::SER_STOP: next_txSt = asec_pkg::SER_IDLE;
					default: next_txSt = asec_pkg::SER_IDLE;
				endcase
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			txSt <= asec_pkg::SER_IDLE;
			txSub <= 7'h00;
			txIdx <= 3'h0;
			txSh <= 8'h00;
			txHold <= 8'h00;
			holdValid <= 1'b0;
			txLine <= 1'b1;
			tx_serial_pin <= 1'b1;
			tx_empty_flag <= 1'b0;
			carrier_rise_event <= 1'b0;
			async_clock_pin_out <= 1'b0;
			async_clock_pin_oe <= 1'b0;
		end else begin
			txSt <= next_txSt;
			txSub <= next_txSub;
			txIdx <= next_txIdx;
			txSh <= next_txSh;
			txHold <= next_txHold;
			holdValid <= next_holdValid;
			txLine <= next_txLine;
			tx_serial_pin <= (ext0[asec_pkg::EXT_SEND_BRK] && brkEn) ? 1'b0 : txLine;
			tx_empty_flag <= !holdValid && !ctsBlock;
			carrier_rise_event <= next_cdSticky;
			async_clock_pin_out <= baud.clkLevel;
			async_clock_pin_oe <= baud.clkDrive;
		end
	end
endmodule // asec_ext_ctrl

// *** verification/asec_ext_ctrl_props.sv ***
// Purpose: Bus and pin checks for the serial extension control
// Assumes: Writes land at the edge that takes the request
// Notes: Register state is shadowed from bus traffic only
`timescale 1ns/10ps
module asec_ext_ctrl_props (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// Wishbone
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [4:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o,
	// Serial pins
	input wire logic rx_serial_pin,
	input wire logic tx_serial_pin,
	input wire logic carrier_detect_in,
	input wire logic clear_to_send_in,
	input wire logic async_clock_pin_in,
	input wire logic async_clock_pin_out,
	input wire logic async_clock_pin_oe,
	// Status
	input wire logic tx_empty_flag,
	input wire logic carrier_rise_event
);
	// ----------------------------------------
	// Register shadows
	// ----------------------------------------
	logic wrTake;
	logic [7:0] extSh;
	logic [7:0] next_extSh;
	logic [2:0] rateSh;
	logic [2:0] next_rateSh;
	assign wrTake = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_sel_i[0];
	always_comb begin
		next_extSh = extSh;
		next_rateSh = rateSh;
		if (rst) begin
			next_extSh = 8'h00;
			next_rateSh = 3'h0;
		end else if (wrTake && wb_adr_i == asec_pkg::OFF_EXT0) begin
			next_extSh = wb_dat_i[7:0];
		end else if (wrTake && wb_adr_i == asec_pkg::OFF_CFG) begin
			next_rateSh = wb_dat_i[2:0];
		end
	end
	always_ff @(posedge ref_clk) begin
		extSh <= next_extSh;
		rateSh <= next_rateSh;
	end
	// ----------------------------------------
	// Properties
	// ----------------------------------------
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);
	sequence s_carrier_up;
		$rose(carrier_detect_in) ##1 carrier_detect_in[*3];
	endsequence
	property p_ack_resp;
		(wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o;
	endproperty
	property p_ack_pulse;
		wb_ack_o |=> !wb_ack_o;
	endproperty
	property p_dat_idle;
		!wb_ack_o |-> wb_dat_o == 32'h0;
	endproperty
	property p_reset_out;
		$fell(rst) |-> tx_serial_pin && !wb_ack_o && !tx_empty_flag && !async_clock_pin_oe
			&& !async_clock_pin_out && !carrier_rise_event && wb_dat_o == 32'h0;
	endproperty
	property p_break_tx;
		(extSh[0] && extSh[2])[*3] |-> !tx_serial_pin;
	endproperty
	property p_cts_block;
		(clear_to_send_in && !extSh[5])[*5] |-> !tx_empty_flag;
	endproperty
	property p_carrier_event;
		s_carrier_up |-> ##[0:4] carrier_rise_event;
	endproperty
	property p_oe_drive;
		(rateSh != 3'h7)[*4] |-> async_clock_pin_oe;
	endproperty
	a_ack_resp: assert property (p_ack_resp) else $error("ack missing after request");
	a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
	a_dat_idle: assert property (p_dat_idle) else $error("read data not zero outside ack");
	a_reset_out: assert property (p_reset_out) else $error("outputs wrong after reset");
	a_break_tx: assert property (p_break_tx) else $error("tx line not held low");
	a_cts_block: assert property (p_cts_block) else $error("tx empty not forced low");
	a_carrier_event: assert property (p_carrier_event) else $error("no carrier rise event");
	a_oe_drive: assert property (p_oe_drive) else $error("clock pin not driven");
endmodule // asec_ext_ctrl_props

bind asec_ext_ctrl asec_ext_ctrl_props asec_ext_ctrl_props_i (.ref_clk, .rst, .wb_cyc_i,
	.wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o,
	.rx_serial_pin, .tx_serial_pin, .carrier_detect_in, .clear_to_send_in,
	.async_clock_pin_in, .async_clock_pin_out, .async_clock_pin_oe, .tx_empty_flag,
	.carrier_rise_event);

// *** verification/asec_serial_peer.sv ***
// Purpose: Remote serial sender on the receive line
// Assumes: 8N1 framing, LSB first, idle high
// Notes: Bit timing counts ref_clk cycles; no bit clock is shared with the device
`timescale 1ns/10ps
module asec_serial_peer (
	// Clock
	input wire logic ref_clk,
	// Line toward the device
	output logic rxLine
);
	initial rxLine = 1'b1;
	// no bit clock shared; low stop bit only on request
	task automatic send_char(input logic [7:0] d, input logic stopBit, input int bitCycles);
		logic [9:0] frame;
		frame = {stopBit, d, 1'b0};
		for (int i = 0; i < 10; i++) begin
			@(posedge ref_clk);
			rxLine <= frame[i];
			repeat (bitCycles - 1) @(posedge ref_clk);
		end
		@(posedge ref_clk);
		rxLine <= 1'b1;
		repeat (2 * bitCycles) @(posedge ref_clk);
	endtask
endmodule // asec_serial_peer

// *** verification/asec_ext_ctrl_tb_top.sv ***
// Purpose: Self-checking bench for the serial extension control
// Assumes: One wait state per bus access, 10 MHz clock
// Notes: External clock pin is pulsed by the bench only in unity mode
`timescale 1ns/10ps
module asec_ext_ctrl_tb_top;
	logic ref_clk;
	logic rst;
	logic wb_cyc_i;
	logic wb_stb_i;
	logic wb_we_i;
	logic [4:0] wb_adr_i;
	logic [3:0] wb_sel_i;
	logic [31:0] wb_dat_i;
	logic [31:0] wb_dat_o;
	logic wb_ack_o;
	logic rx_serial_pin;
	logic tx_serial_pin;
	logic carrier_detect_in;
	logic clear_to_send_in;
	logic async_clock_pin_out;
	logic async_clock_pin_oe;
	logic tx_empty_flag;
	logic carrier_rise_event;
	logic ckIn;
	logic [31:0] rd;
	int miscompares;
	int check_count;
	initial ref_clk = 1'b0;
	always #50 ref_clk = ~ref_clk;
	asec_ext_ctrl asec_ext_ctrl_i (.ref_clk(ref_clk), .rst(rst), .wb_cyc_i(wb_cyc_i),
		.wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
		.wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
		.rx_serial_pin(rx_serial_pin), .tx_serial_pin(tx_serial_pin),
		.carrier_detect_in(carrier_detect_in), .clear_to_send_in(clear_to_send_in),
		.async_clock_pin_in(ckIn), .async_clock_pin_out(async_clock_pin_out),
		.async_clock_pin_oe(async_clock_pin_oe), .tx_empty_flag(tx_empty_flag),
		.carrier_rise_event(carrier_rise_event));
	asec_serial_peer asec_serial_peer_i (.ref_clk(ref_clk), .rxLine(rx_serial_pin));
	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic report_and_stop();
		$display("Comparisons %0d, mismatches %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			$display("Error at %0t: got %h expected %h", $time, got, exp);
			miscompares++;
		end
	endtask
	task automatic wb(input logic we, input logic [4:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge ref_clk);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= a;
		wb_sel_i <= 4'hf;
		wb_dat_i <= d;
		do begin
			@(posedge ref_clk);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 20);
		rd = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		if (wb_ack_o !== 1'b1) begin
			miscompares++;
			report_and_stop();
		end
	endtask
	task automatic rchk(input logic [4:0] a, input logic [31:0] m, input logic [31:0] e);
		wb(1'b0, a, 32'h0);
		check(rd & m, e);
	endtask
	task automatic poll_rx();
		for (int i = 0; i < 400; i++) begin
			wb(1'b0, asec_pkg::OFF_STAT, 32'h0);
			if (rd[0] === 1'b1) break;
		end
		check({31'h0, rd[0]}, 32'h1);
	endtask
	task automatic drain();
		for (int i = 0; i < 8; i++) begin
			wb(1'b0, asec_pkg::OFF_STAT, 32'h0);
			if (rd[0] !== 1'b1) break;
			wb(1'b0, asec_pkg::OFF_DATA, 32'h0);
		end
	endtask
	task automatic wait_lvl(input logic v, inout int n);
		while (async_clock_pin_out !== v && n < 3000) begin
			@(posedge ref_clk);
			n++;
		end
	endtask
	task automatic measure(input int exp);
		int n;
		for (int i = 0; i < 3; i++) begin
			n = 0;
			wait_lvl(1'b0, n);
			wait_lvl(1'b1, n);
		end
		check(32'(n), 32'(exp));
	endtask
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_reset();
		rchk(asec_pkg::OFF_EXT0, 32'hff, 32'h00);
		rchk(asec_pkg::OFF_EXT1, 32'hff, 32'h00);
		check({31'h0, tx_serial_pin}, 32'h1);
		rchk(5'h1c, 32'hffffffff, 32'h0);
	endtask
	task automatic t_regs();
		wb(1'b1, asec_pkg::OFF_EXT0, 32'hff);
		rchk(asec_pkg::OFF_EXT0, 32'hff, 32'h7d);
		wb(1'b1, asec_pkg::OFF_EXT1, 32'hff);
		rchk(asec_pkg::OFF_EXT1, 32'hff, 32'h1d);
		wb(1'b1, asec_pkg::OFF_EXT0, 32'h00);
		wb(1'b1, asec_pkg::OFF_EXT1, 32'h00);
	endtask
	task automatic t_break();
		wb(1'b1, asec_pkg::OFF_EXT0, 32'h04);
		repeat (5) @(posedge ref_clk);
		check({31'h0, tx_serial_pin}, 32'h1);
		wb(1'b1, asec_pkg::OFF_EXT0, 32'h05);
		repeat (60) @(posedge ref_clk);
		check({31'h0, tx_serial_pin}, 32'h0);
		wb(1'b1, asec_pkg::OFF_EXT0, 32'h01);
		repeat (5) @(posedge ref_clk);
		check({31'h0, tx_serial_pin}, 32'h1);
		wb(1'b1, asec_pkg::OFF_EXT0, 32'h00);
	endtask
	task automatic t_cts();
		clear_to_send_in <= 1'b1;
		repeat (6) @(posedge ref_clk);
		check({31'h0, tx_empty_flag}, 32'h0);
		rchk(asec_pkg::OFF_STAT, 32'h10, 32'h10);
		rchk(asec_pkg::OFF_CFG, 32'h20, 32'h20);
		wb(1'b1, asec_pkg::OFF_EXT0, 32'h20);
		repeat (6) @(posedge ref_clk);
		check({31'h0, tx_empty_flag}, 32'h1);
		clear_to_send_in <= 1'b0;
		wb(1'b1, asec_pkg::OFF_EXT0, 32'h00);
	endtask
	task automatic t_baud();
		measure(10);
		wb(1'b1, asec_pkg::OFF_CFG, 32'h09);
		measure(60);
		wb(1'b1, asec_pkg::OFF_TCONST, 32'h05);
		wb(1'b1, asec_pkg::OFF_EXT0, 32'h08);
		measure(14);
		wb(1'b1, asec_pkg::OFF_CFG, 32'h07);
		repeat (4) @(posedge ref_clk);
		check({31'h0, async_clock_pin_oe}, 32'h0);
		wb(1'b1, asec_pkg::OFF_CFG, 32'h00);
	endtask
	task automatic t_unity();
		logic [8:0] d;
		d = 9'h196;
		wb(1'b1, asec_pkg::OFF_CFG, 32'h07);
		wb(1'b1, asec_pkg::OFF_EXT0, 32'h10);
		wb(1'b1, asec_pkg::OFF_DATA, 32'h196);
		repeat (4) @(posedge ref_clk);
		check({31'h0, tx_serial_pin}, 32'h0);
		// Each pin rise is one bit time in unity mode
		for (int i = 0; i < 9; i++) begin
			ckIn <= 1'b1;
			repeat (4) @(posedge ref_clk);
			ckIn <= 1'b0;
			repeat (4) @(posedge ref_clk);
			check({31'h0, tx_serial_pin}, {31'h0, d[i]});
		end
		wb(1'b1, asec_pkg::OFF_CFG, 32'h00);
	endtask
	task automatic t_rx();
		wb(1'b1, asec_pkg::OFF_TCONST, 32'h00);
		wb(1'b1, asec_pkg::OFF_EXT0, 32'h0c);
		asec_serial_peer_i.send_char(8'ha5, 1'b1, 64);
		poll_rx();
		check(rd & 32'h2, 32'h0);
		rchk(asec_pkg::OFF_DATA, 32'hff, 32'ha5);
		asec_serial_peer_i.send_char(8'h00, 1'b0, 64);
		poll_rx();
		check(rd & 32'h2, 32'h2);
		rchk(asec_pkg::OFF_EXT0, 32'hff, 32'h0e);
		// Break tail reads as a new start that fails its half-bit check; let the receiver return to idle first
		repeat (600) @(posedge ref_clk);
		drain();
		wb(1'b1, asec_pkg::OFF_CTRLA, 32'h00);
		rchk(asec_pkg::OFF_EXT0, 32'hff, 32'h0c);
	endtask
	task automatic t_carrier();
		asec_serial_peer_i.send_char(8'h00, 1'b0, 64);
		poll_rx();
		rchk(asec_pkg::OFF_EXT0, 32'hff, 32'h0e);
		carrier_detect_in <= 1'b1;
		repeat (10) @(posedge ref_clk);
		check({31'h0, carrier_rise_event}, 32'h1);
		rchk(asec_pkg::OFF_EXT0, 32'hff, 32'h0c);
		rchk(asec_pkg::OFF_STAT, 32'h29, 32'h28);
		check({31'h0, carrier_rise_event}, 32'h0);
		asec_serial_peer_i.send_char(8'h33, 1'b1, 64);
		rchk(asec_pkg::OFF_STAT, 32'h01, 32'h00);
		wb(1'b1, asec_pkg::OFF_EXT0, 32'h4c);
		asec_serial_peer_i.send_char(8'h5a, 1'b1, 64);
		poll_rx();
		rchk(asec_pkg::OFF_DATA, 32'hff, 32'h5a);
		carrier_detect_in <= 1'b0;
	endtask
	initial begin
		rst = 1'b1;
		wb_cyc_i = 1'b0;
		wb_stb_i = 1'b0;
		wb_we_i = 1'b0;
		wb_adr_i = 5'h00;
		wb_sel_i = 4'h0;
		wb_dat_i = 32'h0;
		carrier_detect_in = 1'b0;
		clear_to_send_in = 1'b0;
		ckIn = 1'b0;
		miscompares = 0;
		check_count = 0;
		repeat (4) @(posedge ref_clk);
		rst <= 1'b0;
		t_reset();
		t_regs();
		t_break();
		t_cts();
		t_baud();
		t_unity();
		t_rx();
		t_carrier();
		report_and_stop();
	end
endmodule // asec_ext_ctrl_tb_top
